// ### src/wdt_top.sv
// Purpose: watchdog timer with guarded control register on the core register bus
// Assumes: xtal_clk is the free-running 32.768 kHz crystal clock, sampled as a pin
// Notes: functional notes below; timing is counted in crystal periods
// Functional notes
// (R1) disabled watchdog takes no timeout action
// (R2) missed refresh while enabled causes reset or interrupt; reserved codes 9-15 never time out
// (R3) 16-bit counter advanced by 32.768 kHz timebase
// (R4) prescale codes 0-7 timed, 8 immediate reset
// (R5) control writes need preceding arming write
// (R6) control register powers up as 10H
// (R7) timeout sets status flag, kept across watchdog reset
// (R8) enable cleared by zero write or watchdog reset
// (R9) action select: zero resets, one interrupts
// (R10) arming lasts exactly one following instruction
// (R11) setting enable clears counter, new period
`timescale 1ns/100ps
module wdt_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // crystal timebase pin
    input wire logic xtal_clk,
    // core register bus, byte access
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    // core register bus, bit access to the same address
    input wire logic sfr_bit_wr,
    input wire logic [2:0] sfr_bit_idx,
    input wire logic sfr_bit_val,
    // instruction boundary from the core
    input wire logic instr_done,
    // read data
    output logic [7:0] sfr_rdata_r,
    // timeout actions
    output logic sys_rst_req_r,
    output logic wdt_irq_r
);
    logic xtal_lvl; // filtered timebase level
    logic xtal_prev_r; // last filtered level, for edge detection
    logic tick; // one core cycle per timebase period
    logic [3:0] pre_r; // timeout_prescale_code
    logic act_r; // timeout_action_select
    logic flag_r; // watchdog_timeout_flag
    logic en_r; // watchdog_enable_refresh
    wdt_pkg::wdt_arm_t arm_r; // arming sequencer
    logic [wdt_pkg::CNT_W-1:0] cnt_r; // watchdog counter
    logic [wdt_pkg::CNT_W-1:0] limit; // last count before timeout
    logic [7:0] ctrl_view; // register as software sees it
    logic sel; // register addressed
    logic any_wr; // byte or bit write to the register
    logic [7:0] wr_val; // effective new byte value
    logic accept; // write taken into the fields
    logic arm_req; // write that only arms
    logic timeout; // timeout event this cycle
    logic rst_action; // timeout resolves to system reset

    // timebase pin enters through the synchroniser
    wdt_sync3 wdt_sync3_inst (
        .clk(ref_clk),
        .rst_b(rst_b),
        .async_in(xtal_clk),
        .level_r(xtal_lvl)
    );

    // rising edge of the settled timebase
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            xtal_prev_r <= 1'b0;
        end else begin
            xtal_prev_r <= xtal_lvl;
        end
    end
    assign tick = xtal_lvl & ~xtal_prev_r; // (R3)

    // register view and write decode; bit writes are read-modify-write
    always_comb begin
        ctrl_view = {pre_r, act_r, flag_r, en_r, arm_r != wdt_pkg::ARM_IDLE};
        sel = (sfr_addr == wdt_pkg::CTRL_ADDR);
        any_wr = sel & (sfr_wr | sfr_bit_wr);
        wr_val = sfr_wdata;
        if (sfr_bit_wr) begin
            wr_val = ctrl_view;
            wr_val[sfr_bit_idx] = sfr_bit_val;
        end
        accept = any_wr & (arm_r == wdt_pkg::ARM_OPEN); // (R5)
        arm_req = any_wr & (arm_r == wdt_pkg::ARM_IDLE) & wr_val[wdt_pkg::ARM_BIT]; // (R5)
    end

    // timeout decision; reserved codes never time out
    always_comb begin
        limit = '1;
        if (pre_r <= wdt_pkg::CODE_MAX_TIMED) begin
            limit = wdt_pkg::CNT_W'((32'd1 << (wdt_pkg::BASE_SHIFT + 32'(pre_r))) - 32'd1); // (R4)
        end
        timeout = 1'b0;
        if (en_r) begin // (R1)
            if (pre_r == wdt_pkg::CODE_IMMEDIATE) begin
                timeout = 1'b1; // (R4)
            end else if (pre_r <= wdt_pkg::CODE_MAX_TIMED) begin
                timeout = tick & (cnt_r == limit); // (R2)
            end
        end
        rst_action = ~act_r | (pre_r == wdt_pkg::CODE_IMMEDIATE); // (R9)
    end

    // arming sequencer: arm, then exactly one instruction may write
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            arm_r <= wdt_pkg::ARM_IDLE;
        end else begin
            case (arm_r)
                wdt_pkg::ARM_IDLE: begin
                    if (arm_req) begin
                        // arming write may end its own instruction at once
                        arm_r <= instr_done ? wdt_pkg::ARM_OPEN : wdt_pkg::ARM_PENDING;
                    end
                end
                wdt_pkg::ARM_PENDING: begin
                    if (instr_done) begin
                        arm_r <= wdt_pkg::ARM_OPEN;
                    end
                end
                wdt_pkg::ARM_OPEN: begin
                    if (accept || instr_done) begin
                        arm_r <= wdt_pkg::ARM_IDLE; // (R10)
                    end
                end
                default: begin
                    arm_r <= wdt_pkg::ARM_IDLE;
                end
            endcase
        end
    end

    // prescale and action fields
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_r <= wdt_pkg::PRE_RESET; // (R6)
            act_r <= wdt_pkg::ACT_RESET;
        end else if (accept) begin
            pre_r <= wr_val[7:wdt_pkg::PRE_LSB];
            act_r <= wr_val[wdt_pkg::ACT_BIT];
        end
    end

    // status flag; a timeout beats a software clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_r <= wdt_pkg::FLAG_RESET;
        end else if (timeout) begin
            flag_r <= 1'b1; // (R7)
        end else if (accept) begin
            flag_r <= wr_val[wdt_pkg::FLAG_BIT];
        end
    end

    // enable; own reset request disarms, flag is left alone for software
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_r <= wdt_pkg::EN_RESET;
        end else if (timeout && rst_action) begin
            en_r <= 1'b0; // (R8)
        end else if (accept) begin
            en_r <= wr_val[wdt_pkg::EN_BIT]; // (R8)
        end
    end

    // counter: held clear while off, restarted on refresh or timeout
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else if (!en_r || timeout || (accept && wr_val[wdt_pkg::EN_BIT])) begin
            cnt_r <= '0; // (R11)
        end else if (tick) begin
            cnt_r <= cnt_r + 1'b1; // (R3)
        end
    end

    // timeout actions, one-cycle pulses
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sys_rst_req_r <= 1'b0;
            wdt_irq_r <= 1'b0;
        end else begin
            sys_rst_req_r <= timeout & rst_action; // (R9)
            wdt_irq_r <= timeout & ~rst_action; // (R9)
        end
    end

    // read data, registered; unmatched address reads zero
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rdata_r <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata_r <= sel ? ctrl_view : 8'h00;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    disabled_quiet_a: assert property (!en_r |=> !sys_rst_req_r && !wdt_irq_r) // (R1)
        else $error("action while watchdog disabled");
    timeout_reset_a: assert property (en_r && pre_r <= 4'h7 && tick && cnt_r == limit && !act_r
        |=> sys_rst_req_r && !en_r) // (R2)
        else $error("expired count did not reset");
    count_step_a: assert property (en_r && tick && !timeout && !accept |=> cnt_r == $past(cnt_r) + 16'h0001) // (R3)
        else $error("counter did not advance on tick");
    immediate_a: assert property (en_r && pre_r == 4'h8 |=> sys_rst_req_r) // (R4)
        else $error("immediate code did not reset");
    unarmed_write_a: assert property (sfr_wr && sel && arm_r == wdt_pkg::ARM_IDLE
        |=> $stable(pre_r) && $stable(act_r)) // (R5)
        else $error("unarmed write changed control");
    flag_set_a: assert property (timeout |=> flag_r) // (R7)
        else $error("timeout flag not set");
    // a software disable landing with the timeout may legally clear the enable
    irq_action_a: assert property (timeout && act_r && pre_r != 4'h8 && !accept
        |=> wdt_irq_r && !sys_rst_req_r && en_r) // (R9)
        else $error("interrupt action wrong");
    arm_expire_a: assert property (arm_r == wdt_pkg::ARM_OPEN && instr_done |=> arm_r == wdt_pkg::ARM_IDLE) // (R10)
        else $error("arming outlived one instruction");
    refresh_clear_a: assert property (accept && wr_val[1] |=> cnt_r == 16'h0000) // (R11)
        else $error("refresh did not clear counter");

    armed_write_c: cover property (arm_r == wdt_pkg::ARM_OPEN && accept);
    irq_seen_c: cover property (wdt_irq_r);
    reset_seen_c: cover property (sys_rst_req_r);
endmodule // wdt_top

// ### src/wdt_pkg.sv
// Purpose: shared constants for the guarded watchdog timer
// Assumes: 8-bit special-function-register bus, 32.768 kHz timebase
// Notes: all offsets, fields, reset values and counts live here
package wdt_pkg;
    // register map
    localparam logic [7:0] CTRL_ADDR = 8'hC0; // watchdog_control byte address
    localparam logic [7:0] CTRL_RESET = 8'h10; // value after power-on
    // field positions inside watchdog_control
    localparam int PRE_LSB = 4; // timeout_prescale_code occupies bits 7..4
    localparam int ACT_BIT = 3; // timeout_action_select
    localparam int FLAG_BIT = 2; // watchdog_timeout_flag
    localparam int EN_BIT = 1; // watchdog_enable_refresh
    localparam int ARM_BIT = 0; // control_write_arm
    // field reset values taken apart from the byte reset value
    localparam logic [3:0] PRE_RESET = CTRL_RESET[7:4];
    localparam logic ACT_RESET = CTRL_RESET[3];
    localparam logic FLAG_RESET = CTRL_RESET[2];
    localparam logic EN_RESET = CTRL_RESET[1];
    // timeout table: code n gives 2^n * 2^9 timebase periods
    localparam int BASE_SHIFT = 9; // 512 periods at code zero
    localparam logic [3:0] CODE_MAX_TIMED = 4'h7; // longest timed code, 2000 ms
    localparam logic [3:0] CODE_IMMEDIATE = 4'h8; // immediate reset code
    localparam int CNT_W = 16; // watchdog counter width
    // clocks, for reference of the figures above
    localparam int XTAL_HZ = 32768; // timebase rate
    localparam int CORE_HZ = 10000000; // ref_clk rate
    localparam int CORE_PER_XTAL = CORE_HZ / XTAL_HZ; // core cycles per timebase period, floor
    // arming sequencer states
    typedef enum logic [1:0] {
        ARM_IDLE = 2'b00, // writes refused unless they arm
        ARM_PENDING = 2'b01, // arming instruction still running
        ARM_OPEN = 2'b10 // next instruction may write
    } wdt_arm_t;
endpackage

// ### src/wdt_sync3.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes: level changes only when stages two and three agree
`timescale 1ns/100ps
module wdt_sync3 (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // asynchronous level in, filtered level out
    input wire logic async_in,
    output logic level_r
);
    logic s1_r; // metastable stage, read only by s2_r
    logic s2_r; // second stage
    logic s3_r; // third stage

    // shift chain
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // accept a change only once the settled stages agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            level_r <= 1'b0;
        end else if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end
endmodule // wdt_sync3

// ### dv/wdt_bench.sv
// Purpose: self-checking bench for the guarded watchdog timer
// Assumes: crystal pin driven fast by the bench, ten core cycles per tick
// Notes: crystal held low during register writes so tick counts are exact
`timescale 1ns/100ps
module watchdog_timer_with_guarded_control_bench;
    // design inputs, all given a value at time zero
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic xtal_clk = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic sfr_bit_wr = 1'b0;
    logic [2:0] sfr_bit_idx = 3'h0;
    logic sfr_bit_val = 1'b0;
    logic instr_done = 1'b0;
    // design outputs
    logic [7:0] sfr_rdata_r;
    logic sys_rst_req_r;
    logic wdt_irq_r;
    // bench state
    logic [31:0] seed = 32'hEAC5B2E8; // fixed seed keeps runs repeatable
    logic [31:0] r;
    logic [7:0] rd_val;
    logic [2:0] bit_sel = 3'h0; // bit number for bit writes, arming bit by default
    logic bit_set = 1'b1; // value for bit writes
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int tick_cnt = 0; // ticks since the last accepted write
    int rst_cnt = 0;
    int irq_cnt = 0;
    int rst_tick = 0;
    int irq_tick = 0;

    wdt_top wdt_top_inst (.ref_clk(ref_clk), .rst_b(rst_b), .xtal_clk(xtal_clk), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
        .sfr_bit_idx(sfr_bit_idx), .sfr_bit_val(sfr_bit_val), .instr_done(instr_done),
        .sfr_rdata_r(sfr_rdata_r), .sys_rst_req_r(sys_rst_req_r), .wdt_irq_r(wdt_irq_r));

    // core clock, 100 ns period
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    // pulse monitor and hang limit; outputs looked at mid-cycle where they are settled
    always @(negedge ref_clk) begin
        cycles++;
        if (sys_rst_req_r === 1'b1) begin
            rst_cnt++;
            rst_tick = tick_cnt;
        end
        if (wdt_irq_r === 1'b1) begin
            irq_cnt++;
            irq_tick = tick_cnt;
        end
        if (cycles > 60000) begin
            bad_count++;
            finish_test();
        end
    end

    // xorshift source for register values
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // timeout length in ticks for a timed prescale code
    function automatic int period_ticks(input int code);
        return 1 << (wdt_pkg::BASE_SHIFT + code);
    endfunction

    // byte and register-value compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    // event count compare
    task automatic chk_n(input int got, input int exp, input string msg);
        total_checks++;
        if (got != exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %0d want %0d", $time, msg, got, exp);
        end
    endtask

    // one-cycle bus transfer, launched and released at falling edges
    task automatic bus(input logic wr, input logic bw, input logic rd, input logic [7:0] a,
        input logic [7:0] d, input logic done);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = wr;
        sfr_bit_wr = bw;
        sfr_bit_idx = bit_sel;
        sfr_bit_val = bit_set;
        sfr_rd = rd;
        instr_done = done;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
        sfr_bit_wr = 1'b0;
        sfr_rd = 1'b0;
        instr_done = 1'b0;
    endtask

    // read: data is settled by the releasing falling edge
    task automatic rd(input logic [7:0] a);
        bus(1'b0, 1'b0, 1'b1, a, 8'h00, 1'b0);
        rd_val = sfr_rdata_r;
    endtask

    // arming bit write, then the data write in the next instruction
    task automatic guarded(input logic [7:0] d);
        bus(1'b0, 1'b1, 1'b0, 8'hC0, 8'h00, 1'b1);
        bus(1'b1, 1'b0, 1'b0, 8'hC0, d, 1'b1);
        rst_cnt = 0;
        irq_cnt = 0;
        tick_cnt = 0;
    endtask

    // arming bit write, then a single-bit write in the next instruction
    task automatic guarded_bit(input logic [2:0] idx, input logic val);
        bus(1'b0, 1'b1, 1'b0, 8'hC0, 8'h00, 1'b1);
        bit_sel = idx;
        bit_set = val;
        bus(1'b0, 1'b1, 1'b0, 8'hC0, 8'h00, 1'b1);
        bit_sel = 3'h0;
        bit_set = 1'b1;
        rst_cnt = 0;
        irq_cnt = 0;
        tick_cnt = 0;
    endtask

    // n crystal ticks, then a quiet gap for the synchroniser to drain
    task automatic run(input int n);
        repeat (n) begin
            repeat (5) @(negedge ref_clk);
            xtal_clk = 1'b1;
            tick_cnt++;
            repeat (5) @(negedge ref_clk);
            xtal_clk = 1'b0;
        end
        repeat (10) @(negedge ref_clk);
    endtask

    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (6) @(negedge ref_clk);
        rst_b = 1'b1;
        rd(8'hC0);
        chk(rd_val, 8'h10, "power-on value");
        rd(8'h55);
        chk(rd_val, 8'h00, "unmapped read");
        bus(1'b1, 1'b0, 1'b0, 8'hC0, 8'h32, 1'b1);
        rd(8'hC0);
        chk(rd_val, 8'h10, "unarmed write taken");
        bus(1'b0, 1'b1, 1'b0, 8'hC0, 8'h00, 1'b1);
        bus(1'b0, 1'b0, 1'b0, 8'hC0, 8'h00, 1'b1);
        bus(1'b1, 1'b0, 1'b0, 8'hC0, 8'h32, 1'b1);
        rd(8'hC0);
        chk(rd_val, 8'h10, "stale arm accepted");
        guarded(8'h32);
        rd(8'hC0);
        chk(rd_val, 8'h32, "armed write lost");
        $display("test register guard done");
        guarded(8'h02);
        run(520);
        chk_n(rst_cnt, 1, "reset pulses");
        chk_n(rst_tick, period_ticks(0), "reset tick");
        chk_n(irq_cnt, 0, "irq on reset action");
        rd(8'hC0);
        chk(rd_val, 8'h04, "after reset timeout");
        guarded(8'h0A);
        run(520);
        chk_n(irq_cnt, 1, "irq pulses");
        chk_n(irq_tick, period_ticks(0), "irq tick");
        rd(8'hC0);
        chk(rd_val, 8'h0E, "after irq timeout");
        $display("test timeout actions done");
        guarded(8'h0A);
        run(400);
        guarded(8'h0A);
        run(500);
        chk_n(irq_cnt, 0, "early irq after refresh");
        run(20);
        chk_n(irq_tick, period_ticks(0), "refreshed period");
        // refresh the way software usually does it: a single-bit set of the enable
        run(100);
        guarded_bit(3'h1, 1'b1);
        run(500);
        chk_n(irq_cnt, 0, "early irq after bit refresh");
        run(20);
        chk_n(irq_tick, period_ticks(0), "bit refreshed period");
        guarded(8'h82);
        run(2);
        chk_n(rst_cnt, 1, "immediate reset");
        rd(8'hC0);
        chk(rd_val, 8'h84, "after immediate reset");
        guarded(8'h00);
        rd(8'hC0);
        chk(rd_val, 8'h00, "zero write kept enable");
        run(520);
        chk_n(rst_cnt + irq_cnt, 0, "action while disabled");
        // reserved codes, random action bit, enabled
        repeat (3) begin
            r = xs();
            guarded({4'(9 + r % 7), r[8], 3'b010});
            run(520);
            chk_n(rst_cnt + irq_cnt, 0, "action on reserved code");
        end
        $display("test disabled and reserved done");
        finish_test();
    end
endmodule // watchdog_timer_with_guarded_control_bench
